// ===== include/bwv_pkg.sv
// Behaviour
// - write descriptor is ten bytes, opcode 2Ah, force flag byte1 bit3, big-endian fields.
// - without force flag and with cache enabled, good status may precede media write.
// - media failure after early good status is flagged later as a deferred error.
// - with force flag set, good status waits until every block reaches the medium.
// - caching devices honour the force flag; non-caching devices may ignore it.
// - write count is contiguous blocks from address; zero moves nothing, completes good.
// - verify descriptor is ten bytes, opcode 2Fh; zero count is good, not an error.
// - verify checks blocks read back without uncorrectable error, not their content.
// - mode list is four header bytes then fourteen page bytes, no block descriptor.
// - header medium type, device parameter and descriptor length read as zero.
// - page code 06h with saveable bit, length 0Bh, cache bit byte2, level byte10.
// - writes to unchangeable page fields are dropped silently, never an error.
// - cache bit clear lets status follow reception; set makes status wait for medium.
// - without media lock ability, cache bit writes ignored and it always reads one.
// - page reports block size in bytes 3-4 and block count in bytes 5-9.
// - power level applies only after power condition 07h was selected.
// - level FFh is full performance, 00h full saving, higher favours performance.
// - read-disable flag byte11 bit3 blocks media reads.
// - write-disable flag byte11 bit2 blocks media writes.
// - format-disable flag byte11 bit1 blocks format, reads one while write disabled.
// - lock-disable flag byte11 bit0, forced to one unless the medium is removable.
// - removable indication is zero for fixed media and one for removable.
// constants and types shared by the command interpreter files.
// assumes nothing beyond a single clock domain.
package bwv_pkg;
    // ------------
    // descriptor layout
    // ------------
    localparam logic [7:0] OPC_WRITE    = 8'h2A;
    localparam logic [7:0] OPC_VERIFY   = 8'h2F;
    localparam logic [7:0] CTRL_VALUE   = 8'h00;
    localparam int         CDB_BYTES    = 10;
    localparam int         CDB_FORCE_BIT = 3;
    localparam int         CDB_LBA_BYTE = 2;
    localparam int         CDB_CNT_BYTE = 7;
    localparam int         CDB_CTRL_BYTE = 9;

    // ------------
    // mode parameter list layout (list byte addresses)
    // ------------
    localparam int         LIST_BYTES   = 18;
    localparam int         PAGE_BASE    = 4;
    localparam logic [5:0] PAGE_CODE    = 6'h06;
    localparam logic [7:0] PAGE_LEN     = 8'h0B;
    localparam logic [4:0] ADR_PAGE0    = 5'h04;
    localparam logic [4:0] ADR_PAGE1    = 5'h05;
    localparam logic [4:0] ADR_CACHE    = 5'h06;
    localparam logic [4:0] ADR_BSIZE_HI = 5'h07;
    localparam logic [4:0] ADR_BSIZE_LO = 5'h08;
    localparam logic [4:0] ADR_BCNT0    = 5'h09;
    localparam logic [4:0] ADR_LEVEL    = 5'h0E;
    localparam logic [4:0] ADR_FLAGS    = 5'h0F;
    localparam int         FLG_READ     = 3;
    localparam int         FLG_WRITE    = 2;
    localparam int         FLG_FORMAT   = 1;
    localparam int         FLG_LOCK     = 0;

    // ------------
    // reset values and power
    // ------------
    localparam logic       RST_CACHE_OFF = 1'b0;
    localparam logic [7:0] RST_LEVEL     = 8'hFF;
    localparam logic [3:0] RST_FLAGS     = 4'h0;
    localparam logic [3:0] PWR_SELF      = 4'h7;
    localparam logic [7:0] LEVEL_MAX     = 8'hFF;

    typedef enum logic [2:0] {
        SNS_NONE, SNS_BAD_OPCODE, SNS_BAD_FIELD, SNS_PROTECT, SNS_MEDIUM
    } bwv_sense_t;

    typedef struct packed {
        logic        is_write;
        logic        is_verify;
        logic        force_media_access;
        logic        ctrl_ok;
        logic [31:0] lba;
        logic [15:0] count;
    } bwv_cmd_t;

    typedef struct packed {
        logic        write_cache_disable;
        logic [7:0]  level;
        logic        read_disabled;
        logic        write_disabled;
        logic        format_disabled;
        logic        lock_disabled;
        logic [15:0] block_size;
        logic [39:0] block_count;
    } bwv_page_t;

    typedef struct packed {
        logic        write;
        logic [31:0] lba;
    } bwv_med_t;

    typedef struct packed {
        logic        good;
        bwv_sense_t  sense;
    } bwv_status_t;
endpackage

// ===== hw/bwv_cdb_decode.sv
// splits a ten byte command descriptor into its fields.
// assumes the descriptor is presented whole, byte 0 at index 0.
`timescale 1ns/1ps
module bwv_cdb_decode
    import bwv_pkg::*;
(
    input  wire logic [9:0][7:0] cdb,
    output bwv_pkg::bwv_cmd_t    cmd
);
    always_comb begin
        cmd.is_write           = (cdb[0] == OPC_WRITE);
        cmd.is_verify          = (cdb[0] == OPC_VERIFY);
        // only the write descriptor carries the force flag
        cmd.force_media_access = cmd.is_write & cdb[1][CDB_FORCE_BIT];
        cmd.ctrl_ok            = (cdb[CDB_CTRL_BYTE] == CTRL_VALUE);
        cmd.lba   = {cdb[CDB_LBA_BYTE], cdb[CDB_LBA_BYTE + 1],
                     cdb[CDB_LBA_BYTE + 2], cdb[CDB_LBA_BYTE + 3]};
        cmd.count = {cdb[CDB_CNT_BYTE], cdb[CDB_CNT_BYTE + 1]};
    end
endmodule

// ===== hw/bwv_page_view.sv
// byte view of the mode parameter list, read data registered.
// assumes page fields already carry their forced values.
`timescale 1ns/1ps
module bwv_page_view
    import bwv_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  bwv_pkg::bwv_page_t page,
    input  wire logic         rd,
    input  wire logic [4:0]   addr,
    output logic [7:0]        rdata
);
    logic [7:0] next_rdata;

    function automatic logic [7:0] list_byte(input bwv_page_t p, input logic [4:0] a);
        logic [7:0] b;
        b = 8'h00;    // header bytes and reserved bits read zero
        case (a)
            ADR_PAGE0:    b = {1'b1, 1'b0, PAGE_CODE};
            ADR_PAGE1:    b = PAGE_LEN;
            ADR_CACHE:    b = {7'h00, p.write_cache_disable};
            ADR_BSIZE_HI: b = p.block_size[15:8];
            ADR_BSIZE_LO: b = p.block_size[7:0];
            ADR_BCNT0:    b = p.block_count[39:32];
            5'h0A:        b = p.block_count[31:24];
            5'h0B:        b = p.block_count[23:16];
            5'h0C:        b = p.block_count[15:8];
            5'h0D:        b = p.block_count[7:0];
            ADR_LEVEL:    b = p.level;
            ADR_FLAGS:    b = {4'h0, p.read_disabled, p.write_disabled,
                               p.format_disabled, p.lock_disabled};
            default:      b = 8'h00;    // beyond byte 17 nothing exists
        endcase
        return b;
    endfunction

    always_comb begin
        next_rdata = rd ? list_byte(page, addr) : rdata;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

// ===== hw/bwv_top.sv
// write / verify command interpreter with the device parameter page.
// assumes the transport delivers whole descriptors and whole blocks, and
// that the media engine answers each request with a one cycle done pulse.
`timescale 1ns/1ps
module bwv_top
    import bwv_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    // command and status
    input  wire logic              cdb_valid,
    input  wire logic [9:0][7:0]   cdb,
    output logic                   cdb_ready,
    output logic                   status_valid,
    output bwv_pkg::bwv_status_t   status,
    // block reception from the host
    input  wire logic              rx_valid,
    output logic                   rx_ready,
    // media engine
    output logic                   med_req,
    output bwv_pkg::bwv_med_t      med,
    input  wire logic              med_done,
    input  wire logic              med_err,
    // deferred error report
    output logic                   deferred_error,
    input  wire logic              deferred_clear,
    // mode parameter list access
    input  wire logic              mp_wr,
    input  wire logic              mp_rd,
    input  wire logic [4:0]        mp_addr,
    input  wire logic [7:0]        mp_wdata,
    output logic [7:0]             mp_rdata,
    // device configuration
    input  wire logic              cache_supported,
    input  wire logic              lock_capable,
    input  wire logic              removable_medium,
    input  wire logic [15:0]       block_size,
    input  wire logic [39:0]       block_count,
    input  wire logic [3:0]        power_cond,
    // policy outputs
    output logic                   read_blocked,
    output logic                   write_blocked,
    output logic                   format_blocked,
    output logic                   lock_blocked,
    output logic                   removable_report,
    output logic                   level_active,
    output logic [7:0]             perf_level
);
    // ------------
    // decode
    // ------------
    bwv_cmd_t  cmd;
    bwv_page_t page;

    bwv_cdb_decode u_decode (
        .cdb (cdb),
        .cmd (cmd)
    );

    // ------------
    // mode page state
    // ------------
    logic       cache_off;
    logic [7:0] level;
    logic [3:0] flags;
    logic       next_cache_off;
    logic [7:0] next_level;
    logic [3:0] next_flags;
    logic       cache_off_eff;
    logic       fmt_eff;
    logic       lock_eff;

    always_comb begin
        next_cache_off = cache_off;
        next_level     = level;
        next_flags     = flags;
        if (mp_wr) begin
            case (mp_addr)
                ADR_CACHE: begin
                    // a drive that cannot hold the media keeps the bit
                    if (lock_capable) begin
                        next_cache_off = mp_wdata[0];
                    end
                end
                ADR_LEVEL: begin
                    next_level = mp_wdata;
                end
                ADR_FLAGS: begin
                    next_flags = mp_wdata[3:0];
                end
                default: begin
                    // fixed fields: drop the write, no error
                    next_flags = flags;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cache_off <= RST_CACHE_OFF;
            level     <= RST_LEVEL;
            flags     <= RST_FLAGS;
        end else begin
            cache_off <= next_cache_off;
            level     <= next_level;
            flags     <= next_flags;
        end
    end

    always_comb begin
        cache_off_eff = cache_off | ~lock_capable;
        fmt_eff       = flags[FLG_FORMAT] | flags[FLG_WRITE];
        lock_eff      = flags[FLG_LOCK] | ~removable_medium;
        page.write_cache_disable = cache_off_eff;
        page.level           = level;
        page.read_disabled   = flags[FLG_READ];
        page.write_disabled  = flags[FLG_WRITE];
        page.format_disabled = fmt_eff;
        page.lock_disabled   = lock_eff;
        page.block_size      = block_size;
        page.block_count     = block_count;
    end

    bwv_page_view u_view (
        .clk    (clk),
        .resetn (resetn),
        .page   (page),
        .rd     (mp_rd),
        .addr   (mp_addr),
        .rdata  (mp_rdata)
    );

    always_comb begin
        read_blocked     = flags[FLG_READ];
        write_blocked    = flags[FLG_WRITE];
        format_blocked   = fmt_eff;
        lock_blocked     = lock_eff;
        removable_report = removable_medium;
        // outside self-managed power the level has no say
        level_active     = (power_cond == PWR_SELF);
        perf_level       = level_active ? level : LEVEL_MAX;
    end

    // ------------
    // command sequencer
    // ------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_MED, ST_FLUSH
    } bwv_state_t;

    bwv_state_t  state;
    bwv_state_t  next_state;
    logic        is_write;
    logic        cached;
    logic [31:0] lba;
    logic [15:0] remain;
    logic        next_is_write;
    logic        next_cached;
    logic [31:0] next_lba;
    logic [15:0] next_remain;
    logic        next_status_valid;
    bwv_status_t next_status;
    logic        next_deferred;
    logic        last;

    always_comb begin
        next_state        = state;
        next_is_write     = is_write;
        next_cached       = cached;
        next_lba          = lba;
        next_remain       = remain;
        next_status_valid = 1'b0;
        next_status       = status;
        next_deferred     = deferred_error;
        last              = (remain == 16'h0001);
        if (deferred_clear) begin
            next_deferred = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (cdb_valid) begin
                    next_status_valid = 1'b1;
                    next_status       = '{good: 1'b0, sense: SNS_NONE};
                    if (!cmd.is_write && !cmd.is_verify) begin
                        next_status.sense = SNS_BAD_OPCODE;
                    end else if (!cmd.ctrl_ok) begin
                        next_status.sense = SNS_BAD_FIELD;
                    end else if (cmd.is_write && flags[FLG_WRITE]) begin
                        next_status.sense = SNS_PROTECT;
                    end else if (cmd.is_verify && flags[FLG_READ]) begin
                        // verify reads the media, so it honours the read lock
                        next_status.sense = SNS_PROTECT;
                    end else if (cmd.count == 16'h0000) begin
                        next_status.good = 1'b1;
                    end else begin
                        next_status_valid = 1'b0;
                        next_is_write     = cmd.is_write;
                        next_lba          = cmd.lba;
                        next_remain       = cmd.count;
                        // without a cache the force flag changes nothing
                        next_cached = cmd.is_write & cache_supported
                                    & ~cmd.force_media_access & ~cache_off_eff;
                        next_state  = cmd.is_write ? ST_RX : ST_MED;
                    end
                end
            end
            ST_RX: begin
                if (rx_valid) begin
                    if (cached && last) begin
                        // data received in full: answer now, finish behind
                        next_status_valid = 1'b1;
                        next_status       = '{good: 1'b1, sense: SNS_NONE};
                        next_state        = ST_FLUSH;
                    end else begin
                        next_state = ST_MED;
                    end
                end
            end
            ST_MED: begin
                if (med_done) begin
                    if (med_err) begin
                        // verify fails only on an unreadable block
                        next_status_valid = 1'b1;
                        next_status       = '{good: 1'b0, sense: SNS_MEDIUM};
                        next_state        = ST_IDLE;
                    end else if (last) begin
                        // every block is on the medium before good
                        next_status_valid = 1'b1;
                        next_status       = '{good: 1'b1, sense: SNS_NONE};
                        next_state        = ST_IDLE;
                    end else begin
                        next_lba    = lba + 32'h0000_0001;
                        next_remain = remain - 16'h0001;
                        next_state  = is_write ? ST_RX : ST_MED;
                    end
                end
            end
            ST_FLUSH: begin
                if (med_done) begin
                    if (med_err) begin
                        // status already went out good; the set beats a clear
                        next_deferred = 1'b1;
                    end
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state          <= ST_IDLE;
            is_write       <= 1'b0;
            cached         <= 1'b0;
            lba            <= 32'h0000_0000;
            remain         <= 16'h0000;
            status_valid   <= 1'b0;
            status         <= '{good: 1'b0, sense: SNS_NONE};
            deferred_error <= 1'b0;
        end else begin
            state          <= next_state;
            is_write       <= next_is_write;
            cached         <= next_cached;
            lba            <= next_lba;
            remain         <= next_remain;
            status_valid   <= next_status_valid;
            status         <= next_status;
            deferred_error <= next_deferred;
        end
    end

    // ------------
    // handshakes
    // ------------
    always_comb begin
        cdb_ready = (state == ST_IDLE);
        rx_ready  = (state == ST_RX);
        med_req   = (state == ST_MED) || (state == ST_FLUSH);
        med.write = is_write;
        med.lba   = lba;
    end
endmodule

// ===== tb/bwv_monitor.sv
// concurrent checks on the command interpreter ports.
// assumes a bind onto bwv_top, one clock domain.
`timescale 1ns/1ps
module bwv_monitor
    import bwv_pkg::*;
(
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            cdb_valid,
    input wire logic [9:0][7:0] cdb,
    input wire logic            cdb_ready,
    input wire logic            rx_ready,
    input wire logic            med_req,
    input wire logic            status_valid,
    input bwv_pkg::bwv_status_t status,
    input wire logic            read_blocked,
    input wire logic            write_blocked,
    input wire logic            format_blocked,
    input wire logic            lock_blocked,
    input wire logic            removable_medium,
    input wire logic            removable_report,
    input wire logic [3:0]      power_cond,
    input wire logic [7:0]      perf_level,
    input wire logic            mp_rd,
    input wire logic [4:0]      mp_addr,
    input wire logic [7:0]      mp_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ------------
    // decoded request
    // ------------
    logic take, opc_ok, ctl_ok, prot;
    assign take   = cdb_valid && cdb_ready;
    assign opc_ok = (cdb[0] == OPC_WRITE) || (cdb[0] == OPC_VERIFY);
    assign ctl_ok = opc_ok && (cdb[9] == 8'h00);
    assign prot   = (cdb[0] == OPC_WRITE) ? write_blocked : read_blocked;
    sequence s_answer(logic g, bwv_sense_t s);
        status_valid && (status.good == g) && (status.sense == s);
    endsequence
    // ------------
    // checks
    // ------------
    a_bad_opcode: assert property (take && !opc_ok |=> s_answer(1'b0, SNS_BAD_OPCODE))
        else $error("unknown opcode not refused");
    a_bad_ctrl_byte: assert property (take && opc_ok && cdb[9] != 8'h00
        |=> s_answer(1'b0, SNS_BAD_FIELD)) else $error("nonzero control byte not refused");
    a_protect_refusal: assert property (take && ctl_ok && prot
        |=> s_answer(1'b0, SNS_PROTECT)) else $error("disabled access not refused");
    a_zero_count_good: assert property (take && ctl_ok && !prot
        && {cdb[7], cdb[8]} == 16'h0000 |=> s_answer(1'b1, SNS_NONE))
        else $error("zero count did not complete good");
    a_format_follows_write: assert property (write_blocked |-> format_blocked)
        else $error("format allowed while writes disabled");
    a_lock_fixed_media: assert property (!removable_medium |-> lock_blocked)
        else $error("lock allowed on fixed medium");
    a_removable_report: assert property (removable_report == removable_medium)
        else $error("removable indication wrong");
    a_level_gate: assert property (power_cond != PWR_SELF |-> perf_level == LEVEL_MAX)
        else $error("level applied without self managed power");
    a_header_zero: assert property (mp_rd && mp_addr < 5'h04 |=> mp_rdata == 8'h00)
        else $error("header byte not zero");
    a_page_code_byte: assert property (mp_rd && mp_addr == ADR_PAGE0 |=> mp_rdata == 8'h86)
        else $error("page code byte wrong");
    a_busy_no_take: assert property (med_req |-> !cdb_ready && !rx_ready)
        else $error("handshake open while media busy");
endmodule

// ===== tb/bwv_media_model.sv
// media engine stand-in: answers each request after lat+1 cycles.
// assumes requests are held until the done pulse.
`timescale 1ns/1ps
module bwv_media_model
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       med_req,
    input  wire logic [7:0] lat,
    input  wire logic       err_on,
    output logic            med_done,
    output logic            med_err
);
    logic [7:0] wait_cnt;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 8'h00;
            med_done <= 1'b0;
            med_err  <= 1'b0;
        end else begin
            med_done <= 1'b0;
            // error line is meaningless outside done, so keep it moving
            med_err  <= ~med_err;
            if (med_req && !med_done) begin
                if (wait_cnt == lat) begin
                    med_done <= 1'b1;
                    med_err  <= err_on;
                    wait_cnt <= 8'h00;
                end else begin
                    wait_cnt <= wait_cnt + 8'h01;
                end
            end
        end
    end
endmodule

// ===== tb/tb_bwv_top.sv
// self-checking bench for bwv_top with a media engine model.
// assumes the package bwv_pkg is compiled first.
`timescale 1ns/1ps
module tb_bwv_top;
    import bwv_pkg::*;
    logic clk, resetn, cdb_valid, cdb_ready, status_valid, rx_valid, rx_ready, exp_wr;
    logic med_req, med_done, med_err, deferred_error, deferred_clear, err_on, mp_wr, mp_rd;
    logic cache_supported, lock_capable, removable_medium, level_active, read_blocked;
    logic write_blocked, format_blocked, lock_blocked, removable_report;
    logic [9:0][7:0] cdb;
    logic [4:0]      mp_addr;
    logic [7:0]      mp_wdata, mp_rdata, perf_level, lat;
    logic [15:0]     block_size;
    logic [39:0]     block_count;
    logic [3:0]      power_cond;
    logic [31:0]     exp_lba;
    bwv_status_t     status;
    bwv_med_t        med;
    int              num_errors, checks, media_ops;
    bwv_top u_bwv_top (.*);
    bwv_media_model u_bwv_media_model (.*);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------
    // shared tasks
    // ------------
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge clk) begin
        if (resetn && med_req && med_done) begin
            chk("media lba", med.lba, exp_lba);
            chk("media dir", med.write, exp_wr);
            exp_lba++;
            media_ops++;
        end
    end
    task automatic wait_idle();
        @(negedge clk);
        for (int n = 0; n < 300 && cdb_ready !== 1'b1; n++) @(negedge clk);
        chk("idle", cdb_ready, 1'b1);
    endtask
    task automatic run(input logic [7:0] op, input logic [15:0] cnt, input bwv_sense_t s,
                       input int ops, input logic f = 1'b0, input logic [7:0] ctl = 8'h00);
        int n;
        wait_idle();
        cdb = '0;
        cdb[0] = op;
        cdb[1] = {4'h0, f, 3'h0};
        {cdb[2], cdb[3], cdb[4], cdb[5]} = 32'h0102_0304;
        {cdb[7], cdb[8]} = cnt;
        cdb[9] = ctl;
        cdb_valid = 1'b1;
        rx_valid = 1'b1;
        media_ops = 0;
        exp_lba = 32'h0102_0304;
        exp_wr = (op == OPC_WRITE);
        @(negedge clk) cdb_valid = 1'b0;
        for (n = 0; n < 300 && status_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("status valid", status_valid, 1'b1);
        chk("status good", status.good, s == SNS_NONE);
        chk("status sense", status.sense, s);
        chk("media ops", media_ops, ops);
        @(negedge clk) rx_valid = 1'b0;
    endtask
    task automatic mp_put(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk) {mp_wr, mp_addr, mp_wdata} = {1'b1, a, d};
        @(negedge clk) mp_wr = 1'b0;
    endtask
    task automatic mp_get(input logic [4:0] a, input logic [7:0] e);
        @(negedge clk) {mp_rd, mp_addr} = {1'b1, a};
        @(negedge clk) mp_rd = 1'b0;
        chk("mode byte", mp_rdata, e);
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_list();
        logic [7:0] e;
        for (int i = 0; i < 20; i++) begin
            e = 8'h00;
            case (i)
                4: e = 8'h86;
                5: e = 8'h0B;
                7: e = block_size[15:8];
                8: e = block_size[7:0];
                9, 10, 11, 12, 13: e = block_count[8*(13-i) +: 8];
                14: e = 8'hFF;
                default: e = 8'h00;
            endcase
            mp_get(5'(i), e);
        end
    endtask
    task automatic t_commands();
        run(8'h28, 16'h0001, SNS_BAD_OPCODE, 0);
        run(OPC_WRITE, 16'h0001, SNS_BAD_FIELD, 0, 1'b0, 8'h01);
        run(OPC_WRITE, 16'h0003, SNS_NONE, 3, 1'b1);
        run(OPC_WRITE, 16'h0002, SNS_NONE, 1);
        cache_supported = 1'b0;
        run(OPC_WRITE, 16'h0002, SNS_NONE, 2);
        cache_supported = 1'b1;
        run(OPC_WRITE, 16'h0000, SNS_NONE, 0);
        run(OPC_VERIFY, 16'h0002, SNS_NONE, 2);
        run(OPC_VERIFY, 16'h0000, SNS_NONE, 0);
        err_on = 1'b1;
        run(OPC_VERIFY, 16'h0002, SNS_MEDIUM, 1);
        run(OPC_WRITE, 16'h0001, SNS_MEDIUM, 1, 1'b1);
        run(OPC_WRITE, 16'h0001, SNS_NONE, 0);
        wait_idle();
        @(negedge clk) err_on = 1'b0;
        chk("deferred error", deferred_error, 1'b1);
        deferred_clear = 1'b1;
        @(negedge clk) deferred_clear = 1'b0;
        chk("deferred cleared", deferred_error, 1'b0);
    endtask
    task automatic t_page();
        mp_put(ADR_CACHE, 8'h01);
        mp_get(ADR_CACHE, 8'h01);
        run(OPC_WRITE, 16'h0002, SNS_NONE, 2);
        lock_capable = 1'b0;
        mp_put(ADR_CACHE, 8'h00);
        lock_capable = 1'b1;
        mp_get(ADR_CACHE, 8'h01);
        mp_put(ADR_CACHE, 8'h00);
        lock_capable = 1'b0;
        mp_get(ADR_CACHE, 8'h01);
        run(OPC_WRITE, 16'h0002, SNS_NONE, 2);
        lock_capable = 1'b1;
        mp_put(ADR_PAGE1, 8'h55);
        mp_get(ADR_PAGE1, 8'h0B);
        mp_put(ADR_FLAGS, 8'h04);
        mp_get(ADR_FLAGS, 8'h06);
        run(OPC_WRITE, 16'h0001, SNS_PROTECT, 0);
        run(OPC_VERIFY, 16'h0001, SNS_NONE, 1);
        mp_put(ADR_FLAGS, 8'h08);
        run(OPC_VERIFY, 16'h0001, SNS_PROTECT, 0);
        removable_medium = 1'b0;
        mp_get(ADR_FLAGS, 8'h09);
        chk("removable report", removable_report, 1'b0);
        removable_medium = 1'b1;
        mp_put(ADR_FLAGS, 8'h00);
        mp_put(ADR_LEVEL, 8'h40);
        chk("level idle", perf_level, 8'hFF);
        power_cond = PWR_SELF;
        @(negedge clk);
        chk("level self", perf_level, 8'h40);
        chk("level active", level_active, 1'b1);
    endtask
    // ------------
    // main sequence and watchdog
    // ------------
    initial begin
        {cdb_valid, rx_valid, deferred_clear, mp_wr, mp_rd, err_on, resetn} = '0;
        {cdb, mp_addr, mp_wdata, power_cond} = '0;
        {cache_supported, lock_capable, removable_medium} = 3'b111;
        block_size = 16'h0200;
        block_count = 40'h00_1234_5678;
        lat = 8'h03;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        t_list();
        t_commands();
        t_page();
        results();
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule
bind bwv_top bwv_monitor u_bwv_monitor (.*);
